// file: hw/acfg_pkg.sv
// package for the input configuration and sequence block: field layout, codes, enums
// assumes the serial word is sixteen bits, most significant bit first
package acfg_pkg;

    // ----------------------------------------------------------------
    // serial word layout
    // ----------------------------------------------------------------
    localparam int WORD_BITS = 16;
    localparam int WORD_MSB = 15;
    localparam int CODE_HI = 15;
    localparam int CODE_LO = 11;
    localparam int FIELD_HI = 10;
    localparam int FIELD_LO = 3;
    localparam int COMREF_BIT = 2;
    localparam logic [4:0] BITCNT_LAST = 5'h0F;

    // ----------------------------------------------------------------
    // register select codes
    // ----------------------------------------------------------------
    localparam logic [4:0] PAIRING_REG_SELECT_CODE = 5'h11;
    localparam logic [4:0] POLARITY_REG_SELECT_CODE = 5'h12;
    localparam logic [4:0] SEQUENCE_REG_SELECT_CODE = 5'h16;

    // ----------------------------------------------------------------
    // reset values and sizes
    // ----------------------------------------------------------------
    localparam logic [7:0] PAIRING_RESET = 8'h00;
    localparam logic [7:0] POLARITY_RESET = 8'h00;
    localparam logic COMREF_RESET = 1'b0;
    localparam logic [7:0] SEQ_LEN_RESET = 8'h00;
    localparam int SEQ_DEPTH = 256;
    localparam int SEQ_ADDR_W = 8;
    localparam int NIBBLE_W = 4;
    localparam logic [3:0] DEFAULT_CHANNEL = 4'h0;

    // ----------------------------------------------------------------
    // enumerations
    // ----------------------------------------------------------------
    typedef enum logic [4:0] {
        ST_IDLE      = 5'h01,
        ST_CMD_FRAME = 5'h02,
        ST_ARMED     = 5'h04,
        ST_PAT_FRAME = 5'h08,
        ST_PAT_DONE  = 5'h10
    } acfg_state_t;

    // channel source chosen by the scan mode logic outside
    typedef enum logic [1:0] {
        SRC_FIELD    = 2'h0,
        SRC_BITMAP   = 2'h1,
        SRC_SEQUENCE = 2'h2
    } acfg_src_t;

    // how the selected channel is converted
    typedef enum logic [1:0] {
        IN_SINGLE_ENDED = 2'h0,
        IN_PSEUDO_DIFF  = 2'h1,
        IN_FULLY_DIFF   = 2'h2,
        IN_COMMON_REF   = 2'h3
    } acfg_in_mode_t;

endpackage : acfg_pkg

// file: hw/acfg_seq_mem.sv
// channel sequence store: one write port, one read port with registered data
// assumes the writer and reader share one clock
`timescale 1ns/1ps
module acfg_seq_mem #(
    parameter int DEPTH = 256,
    parameter int ADDR_W = 8,
    parameter int WIDTH = 4
) (
    input wire logic clk,
    input wire logic we,
    input wire logic [ADDR_W-1:0] waddr,
    input wire logic [WIDTH-1:0] wdata,
    input wire logic [ADDR_W-1:0] raddr,
    output logic [WIDTH-1:0] rdata
);

    logic [WIDTH-1:0] mem [DEPTH];

    // ----------------------------------------------------------------
    // storage; no reset, entries past the loaded count are masked above
    // ----------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
        rdata <= mem[raddr];
    end

endmodule : acfg_seq_mem

// file: hw/acfg_top.sv
// input pairing, polarity and channel sequence logic behind the serial link
// assumes SCLK, CSN and DIN come from the host and are asynchronous to SYS_CLK;
// scan source and step inputs come from converter logic on SYS_CLK
// CSN must stand high when RSTN is released, or the first frame may be missed
//
// How it works
// - code 10001 in 15:11 writes pairing register
// - bits 10:3 pick pseudo-differential pairs, reset 0
// - bit 2 refers inputs to shared input 15
// - code 10010 in 15:11 writes polarity register
// - bits 10:3 pick bipolar differential pairs, reset 0
// - polarity alone gives two's complement differential
// - pairing bit beats polarity bit, binary output
// - common reference overrides pair bits, binary
// - all clear: single-ended binary, any pair
// - field or bitmap selects channel per mode
// - sequence holds up to 256 conversions
// - each entry is one 4-bit channel nibble
// - new sequence goes live at next falling CSN
// - missing entries read as channel 0
// - nibbles past length dropped until CSN rises
// - nibble cut by CSN stored as channel 0
// - code 10110 loads length minus one
// - msb 1 configures, msb 0 is mode command
`timescale 1ns/1ps
module acfg_top #(
    parameter int SEQ_DEPTH = acfg_pkg::SEQ_DEPTH
) (
    input wire logic SYS_CLK,
    input wire logic RSTN,
    input wire logic SCLK,
    input wire logic CSN,
    input wire logic DIN,
    input wire logic [1:0] SCAN_SOURCE,
    input wire logic [3:0] CHANNEL_NUMBER_FIELD,
    input wire logic [15:0] PER_CHANNEL_SCAN_BITMAP,
    input wire logic CONV_NEXT,
    output logic [3:0] CONV_CHANNEL,
    output logic [1:0] CONV_INPUT_MODE,
    output logic CONV_TWOS_COMPLEMENT,
    output logic [7:0] PAIR_PSEUDO_DIFF,
    output logic [7:0] PAIR_BIPOLAR,
    output logic COMMON_REFERENCE_ENABLE,
    output logic [7:0] SEQUENCE_LENGTH_MINUS_ONE,
    output logic [8:0] SEQUENCE_LOADED_COUNT,
    output logic SEQUENCE_ACTIVATED,
    output logic MODE_CMD_VALID,
    output logic [15:0] MODE_CMD_WORD
);

    // ----------------------------------------------------------------
    // state record
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [2:0] sclk_s;
        logic [2:0] csn_s;
        logic [1:0] din_s;
        acfg_pkg::acfg_state_t state;
        logic [4:0] bitcnt;
        logic word_done;
        logic [15:0] shift;
        logic [3:0] nib;
        logic [1:0] nibcnt;
        logic [8:0] nib_idx;
        logic [7:0] pairing;
        logic [7:0] polarity;
        logic comref;
        logic [7:0] len_pend;
        logic [8:0] cnt_pend;
        logic [7:0] len_act;
        logic [8:0] cnt_act;
        logic activated;
        logic [7:0] seq_ptr;
        logic seq_hit_d;
        logic [3:0] bmp_ptr;
        logic [3:0] chan;
        logic [1:0] in_mode;
        logic twos;
        logic cmd_valid;
        logic [15:0] cmd_word;
    } acfg_regs_t;

    acfg_regs_t st_r;
    acfg_regs_t st_nxt;
    logic mem_we;
    logic [7:0] mem_waddr;
    logic [3:0] mem_wdata;
    logic [3:0] mem_rdata;

    // ----------------------------------------------------------------
    // sequence store
    // ----------------------------------------------------------------
    // read address is the live pointer, so read data trail it by one cycle
    acfg_seq_mem #(
        .DEPTH(SEQ_DEPTH),
        .ADDR_W(acfg_pkg::SEQ_ADDR_W),
        .WIDTH(acfg_pkg::NIBBLE_W)
    ) u_seq_mem (
        .clk(SYS_CLK),
        .we(mem_we),
        .waddr(mem_waddr),
        .wdata(mem_wdata),
        .raddr(st_r.seq_ptr),
        .rdata(mem_rdata)
    );

    // ----------------------------------------------------------------
    // next-state logic
    // ----------------------------------------------------------------
    logic sclk_rise;
    logic cs_fall;
    logic cs_rise;
    logic bit_in;
    logic [15:0] word;
    logic [4:0] code;
    logic [3:0] src_chan;
    logic [3:0] bmp_pick;
    logic bmp_found;
    logic [2:0] pair;
    logic [4:0] probe;
    logic [3:0] pch;

    always_comb begin
        st_nxt = st_r;
        mem_we = 1'b0;
        mem_waddr = st_r.nib_idx[7:0];
        mem_wdata = acfg_pkg::DEFAULT_CHANNEL;
        word = '0;
        code = '0;
        bmp_pick = st_r.bmp_ptr;
        bmp_found = 1'b0;
        probe = '0;
        pch = '0;
        src_chan = acfg_pkg::DEFAULT_CHANNEL;
        pair = '0;
        st_nxt.cmd_valid = 1'b0;
        st_nxt.activated = 1'b0;

        // pins pass two flops; the third stage only serves edge detection
        st_nxt.sclk_s = {st_r.sclk_s[1:0], SCLK};
        st_nxt.csn_s = {st_r.csn_s[1:0], CSN};
        st_nxt.din_s = {st_r.din_s[0], DIN};
        sclk_rise = st_r.sclk_s[1] & ~st_r.sclk_s[2];
        cs_fall = ~st_r.csn_s[1] & st_r.csn_s[2];
        cs_rise = st_r.csn_s[1] & ~st_r.csn_s[2];
        bit_in = st_r.din_s[1];

        // ------------------------------------------------------------
        // frame sequencer: command frames, then the two-frame pattern load
        // ------------------------------------------------------------
        case (st_r.state)
            acfg_pkg::ST_IDLE: begin
                if (cs_fall) begin
                    st_nxt.state = acfg_pkg::ST_CMD_FRAME;
                    st_nxt.bitcnt = '0;
                    st_nxt.word_done = 1'b0;
                end
            end
            acfg_pkg::ST_CMD_FRAME: begin
                if (cs_rise) begin
                    // a length word arms the pattern frame that follows
                    if (st_r.word_done && st_r.shift[acfg_pkg::WORD_MSB]
                        && st_r.shift[acfg_pkg::CODE_HI:acfg_pkg::CODE_LO]
                           == acfg_pkg::SEQUENCE_REG_SELECT_CODE) begin
                        st_nxt.state = acfg_pkg::ST_ARMED;
                    end else begin
                        st_nxt.state = acfg_pkg::ST_IDLE;
                    end
                end else if (sclk_rise && !st_r.word_done) begin
                    // msb first; the count stops at sixteen so long frames do no harm
                    word = {st_r.shift[14:0], bit_in};
                    st_nxt.shift = word;
                    st_nxt.bitcnt = st_r.bitcnt + 5'h01;
                    if (st_r.bitcnt == acfg_pkg::BITCNT_LAST) begin
                        // bits after the sixteenth are not looked at
                        st_nxt.word_done = 1'b1;
                        code = word[acfg_pkg::CODE_HI:acfg_pkg::CODE_LO];
                        if (word[acfg_pkg::WORD_MSB]) begin
                            // other codes belong to registers kept elsewhere
                            case (code)
                                acfg_pkg::PAIRING_REG_SELECT_CODE: begin
                                    st_nxt.pairing =
                                        word[acfg_pkg::FIELD_HI:acfg_pkg::FIELD_LO];
                                    st_nxt.comref = word[acfg_pkg::COMREF_BIT];
                                end
                                acfg_pkg::POLARITY_REG_SELECT_CODE: begin
                                    st_nxt.polarity =
                                        word[acfg_pkg::FIELD_HI:acfg_pkg::FIELD_LO];
                                end
                                acfg_pkg::SEQUENCE_REG_SELECT_CODE: begin
                                    st_nxt.len_pend =
                                        word[acfg_pkg::FIELD_HI:acfg_pkg::FIELD_LO];
                                end
                                default: begin
                                end
                            endcase
                        end else begin
                            st_nxt.cmd_valid = 1'b1;
                            st_nxt.cmd_word = word;
                        end
                    end
                end
            end
            acfg_pkg::ST_ARMED: begin
                // the next frame carries nibbles, whatever it holds
                if (cs_fall) begin
                    st_nxt.state = acfg_pkg::ST_PAT_FRAME;
                    st_nxt.nibcnt = '0;
                    st_nxt.nib_idx = '0;
                end
            end
            acfg_pkg::ST_PAT_FRAME: begin
                if (cs_rise) begin
                    // a cut nibble still takes its slot, as channel 0
                    if (st_r.nibcnt != 2'h0
                        && st_r.nib_idx <= {1'b0, st_r.len_pend}) begin
                        mem_we = 1'b1;
                        mem_wdata = acfg_pkg::DEFAULT_CHANNEL;
                        st_nxt.nib_idx = st_r.nib_idx + 9'h001;
                    end
                    st_nxt.state = acfg_pkg::ST_PAT_DONE;
                end else if (sclk_rise) begin
                    // four rising edges make one entry, msb first
                    st_nxt.nib = {st_r.nib[2:0], bit_in};
                    st_nxt.nibcnt = st_r.nibcnt + 2'h1;
                    if (st_r.nibcnt == 2'h3) begin
                        // entries beyond the length are dropped until cs rises
                        if (st_r.nib_idx <= {1'b0, st_r.len_pend}) begin
                            mem_we = 1'b1;
                            mem_wdata = {st_r.nib[2:0], bit_in};
                            st_nxt.nib_idx = st_r.nib_idx + 9'h001;
                        end
                    end
                end
            end
            acfg_pkg::ST_PAT_DONE: begin
                // the count is parked here so activation copies a settled value
                st_nxt.cnt_pend = st_r.nib_idx;
                if (cs_fall) begin
                    // the new pattern goes live and this frame is a command frame
                    st_nxt.len_act = st_r.len_pend;
                    st_nxt.cnt_act = st_r.cnt_pend;
                    st_nxt.seq_ptr = '0;
                    st_nxt.activated = 1'b1;
                    st_nxt.state = acfg_pkg::ST_CMD_FRAME;
                    st_nxt.bitcnt = '0;
                    st_nxt.word_done = 1'b0;
                end
            end
            default: begin
                // a corrupt state code falls back to idle rather than locking up
                st_nxt.state = acfg_pkg::ST_IDLE;
            end
        endcase

        // ------------------------------------------------------------
        // channel selection and input decode
        // ------------------------------------------------------------
        // sequence walk; entries not sent read back as channel 0
        // the activation cycle wins over an advance, so entry 0 is never skipped
        st_nxt.seq_hit_d = {1'b0, st_r.seq_ptr} < st_r.cnt_act;
        if (CONV_NEXT && SCAN_SOURCE == acfg_pkg::SRC_SEQUENCE && !st_nxt.activated) begin
            st_nxt.seq_ptr = (st_r.seq_ptr == st_r.len_act) ? 8'h00 : st_r.seq_ptr + 8'h01;
        end

        // bitmap walk: lowest enabled channel at or after the pointer, wrapping
        for (int i = 15; i >= 0; i--) begin
            probe = {1'b0, st_r.bmp_ptr} + 5'(i);
            pch = probe[3:0];
            if (PER_CHANNEL_SCAN_BITMAP[pch]) begin
                bmp_pick = pch;
                bmp_found = 1'b1;
            end
        end
        // an empty bitmap leaves the pointer where it is
        if (CONV_NEXT && SCAN_SOURCE == acfg_pkg::SRC_BITMAP && bmp_found) begin
            st_nxt.bmp_ptr = bmp_pick + 4'h1;
        end

        // channel source per scan mode
        // the unused source code falls back to the field, the safest choice
        case (SCAN_SOURCE)
            acfg_pkg::SRC_BITMAP: src_chan = bmp_pick;
            acfg_pkg::SRC_SEQUENCE: src_chan = st_r.seq_hit_d ? mem_rdata
                                                              : acfg_pkg::DEFAULT_CHANNEL;
            default: src_chan = CHANNEL_NUMBER_FIELD;
        endcase
        st_nxt.chan = src_chan;

        // input decode: common reference, then pairing, then polarity
        // register bit 7 belongs to pair 0/1, so the index runs downwards
        pair = src_chan[3:1];
        if (st_r.comref) begin
            st_nxt.in_mode = acfg_pkg::IN_COMMON_REF;
            st_nxt.twos = 1'b0;
        end else if (st_r.pairing[3'h7 - pair]) begin
            st_nxt.in_mode = acfg_pkg::IN_PSEUDO_DIFF;
            st_nxt.twos = 1'b0;
        end else if (st_r.polarity[3'h7 - pair]) begin
            st_nxt.in_mode = acfg_pkg::IN_FULLY_DIFF;
            st_nxt.twos = 1'b1;
        end else begin
            st_nxt.in_mode = acfg_pkg::IN_SINGLE_ENDED;
            st_nxt.twos = 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // state register
    // ----------------------------------------------------------------
    always_ff @(posedge SYS_CLK) begin
        if (!RSTN) begin
            // clear the whole record, then set fields whose reset is not plain zero
            st_r <= '0;
            st_r.sclk_s <= 3'h0;
            st_r.csn_s <= 3'h7; // idle deselected so reset does not fake an edge
            st_r.state <= acfg_pkg::ST_IDLE;
            st_r.pairing <= acfg_pkg::PAIRING_RESET;
            st_r.polarity <= acfg_pkg::POLARITY_RESET;
            st_r.comref <= acfg_pkg::COMREF_RESET;
            st_r.len_pend <= acfg_pkg::SEQ_LEN_RESET;
            st_r.len_act <= acfg_pkg::SEQ_LEN_RESET;
        end else begin
            st_r <= st_nxt;
        end
    end

    // ----------------------------------------------------------------
    // outputs, all from the state register
    // ----------------------------------------------------------------
    assign CONV_CHANNEL = st_r.chan;
    assign CONV_INPUT_MODE = st_r.in_mode;
    assign CONV_TWOS_COMPLEMENT = st_r.twos;
    assign PAIR_PSEUDO_DIFF = st_r.pairing;
    assign PAIR_BIPOLAR = st_r.polarity;
    assign COMMON_REFERENCE_ENABLE = st_r.comref;
    assign SEQUENCE_LENGTH_MINUS_ONE = st_r.len_act;
    assign SEQUENCE_LOADED_COUNT = st_r.cnt_act;
    assign SEQUENCE_ACTIVATED = st_r.activated;
    assign MODE_CMD_VALID = st_r.cmd_valid;
    assign MODE_CMD_WORD = st_r.cmd_word;

endmodule : acfg_top

// file: dv/acfg_host.sv
// host model: drives the three-wire link, one word or bit string per chip-select frame
// assumes the bench calls xfer and waits for it to return before the next call
`timescale 1ns/1ps
module acfg_host (
    output logic sclk,
    output logic csn,
    output logic din
);
    // ------------------------------------------------------------
    // link driver
    // ------------------------------------------------------------
    // idle: clock stands low, select high, data line low
    initial begin
        sclk = 1'b0;
        csn = 1'b1;
        din = 1'b0;
    end

    // send the low n bits of d, msb first, inside one frame
    task automatic xfer(input logic [63:0] d, input int n);
        csn = 1'b0;
        #48;
        for (int i = n - 1; i >= 0; i--) begin
            din = d[i]; // nibbles run back to back, msb first
            #24 sclk = 1'b1;
            #24 sclk = 1'b0;
        end
        #48 csn = 1'b1;
        din = ~din; // released line must not keep showing the last bit
        #96;
    endtask : xfer
endmodule : acfg_host

// file: dv/acfg_top_props.sv
// checker for acfg_top: pulse widths, update causes and channel decode at the ports
// assumes it is bound to every acfg_top instance, one clock domain
`timescale 1ns/1ps
module acfg_top_props #(
    parameter int SEQ_DEPTH = 256
) (
    input wire logic SYS_CLK,
    input wire logic RSTN,
    input wire logic CSN,
    input wire logic [1:0] SCAN_SOURCE,
    input wire logic [3:0] CHANNEL_NUMBER_FIELD,
    input wire logic [1:0] CONV_INPUT_MODE,
    input wire logic CONV_TWOS_COMPLEMENT,
    input wire logic [7:0] PAIR_PSEUDO_DIFF,
    input wire logic [7:0] PAIR_BIPOLAR,
    input wire logic COMMON_REFERENCE_ENABLE,
    input wire logic [7:0] SEQUENCE_LENGTH_MINUS_ONE,
    input wire logic [8:0] SEQUENCE_LOADED_COUNT,
    input wire logic SEQUENCE_ACTIVATED,
    input wire logic MODE_CMD_VALID
);
    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (!RSTN);

    // expected mode of a pair without common reference: pairing beats polarity
    function automatic logic [1:0] em(logic [7:0] pd, logic [7:0] bp, logic [3:0] ch);
        logic [2:0] k;
        k = 3'h7 - ch[3:1];
        if (pd[k]) return acfg_pkg::IN_PSEUDO_DIFF;
        if (bp[k]) return acfg_pkg::IN_FULLY_DIFF;
        return acfg_pkg::IN_SINGLE_ENDED;
    endfunction : em

    a_cmd_one_cycle: assert property (MODE_CMD_VALID |=> !MODE_CMD_VALID)
        else $error("mode command pulse longer than one cycle");
    a_act_one_cycle: assert property (SEQUENCE_ACTIVATED |=> !SEQUENCE_ACTIVATED)
        else $error("activation pulse longer than one cycle");
    a_act_after_select: assert property (SEQUENCE_ACTIVATED |-> !$past(CSN, 2))
        else $error("sequence activated without chip select low");
    a_len_on_activate: assert property (!$stable(SEQUENCE_LENGTH_MINUS_ONE) |-> SEQUENCE_ACTIVATED)
        else $error("sequence length changed outside activation");
    a_twos_only_diff: assert property (CONV_TWOS_COMPLEMENT == (CONV_INPUT_MODE == 2'h2))
        else $error("two's complement flag does not match fully differential mode");
    a_comref_wins: assert property (SCAN_SOURCE == 2'h0 && $past(COMMON_REFERENCE_ENABLE)
        |-> CONV_INPUT_MODE == acfg_pkg::IN_COMMON_REF)
        else $error("common reference did not override pair bits");
    a_pair_decode: assert property (SCAN_SOURCE == 2'h0 && $past(SCAN_SOURCE) == 2'h0
        && !$past(COMMON_REFERENCE_ENABLE) |-> CONV_INPUT_MODE == em($past(PAIR_PSEUDO_DIFF),
        $past(PAIR_BIPOLAR), $past(CHANNEL_NUMBER_FIELD)))
        else $error("pair input mode decoded wrongly");
    a_cmd_keeps_regs: assert property (MODE_CMD_VALID |-> $stable(PAIR_PSEUDO_DIFF)
        && $stable(PAIR_BIPOLAR) && $stable(COMMON_REFERENCE_ENABLE))
        else $error("mode command word changed a configuration register");
    a_count_bound: assert property (SEQUENCE_LOADED_COUNT <= SEQ_DEPTH)
        else $error("loaded count above sequence depth");
endmodule : acfg_top_props

bind acfg_top acfg_top_props #(.SEQ_DEPTH(SEQ_DEPTH)) u_acfg_top_props (
    .SYS_CLK(SYS_CLK), .RSTN(RSTN), .CSN(CSN), .SCAN_SOURCE(SCAN_SOURCE),
    .CHANNEL_NUMBER_FIELD(CHANNEL_NUMBER_FIELD), .CONV_INPUT_MODE(CONV_INPUT_MODE),
    .CONV_TWOS_COMPLEMENT(CONV_TWOS_COMPLEMENT), .PAIR_PSEUDO_DIFF(PAIR_PSEUDO_DIFF),
    .PAIR_BIPOLAR(PAIR_BIPOLAR), .COMMON_REFERENCE_ENABLE(COMMON_REFERENCE_ENABLE),
    .SEQUENCE_LENGTH_MINUS_ONE(SEQUENCE_LENGTH_MINUS_ONE),
    .SEQUENCE_LOADED_COUNT(SEQUENCE_LOADED_COUNT), .SEQUENCE_ACTIVATED(SEQUENCE_ACTIVATED),
    .MODE_CMD_VALID(MODE_CMD_VALID));

// file: dv/acfg_top_test.sv
// self-checking bench for acfg_top: host frames in, registers and channel outputs checked
// assumes the host model owns the serial pins and the bench the converter-side inputs
`timescale 1ns/1ps
module acfg_top_test;
    logic sys_clk, rstn, sclk, csn, din, conv_next, twos, cr, act, cmd_v;
    logic [1:0] src, mode;
    logic [3:0] fld, chan;
    logic [15:0] bmap, cmd_word;
    logic [7:0] pd, bp, len;
    logic [8:0] cnt;
    int n_errors = 0;
    int num_checks = 0;
    int n_act = 0;
    int n_cmd = 0;
    // decode table entries: channel, 0, expected mode, expected two's complement
    logic [7:0] dec [6] = '{8'h05, 8'h15, 8'h22, 8'h32, 8'h50, 8'hF0};
    logic [3:0] seq_a [5] = '{4'h5, 4'hA, 4'h0, 4'h0, 4'h5};

    acfg_host u_acfg_host (.sclk(sclk), .csn(csn), .din(din));
    acfg_top u_acfg_top (.SYS_CLK(sys_clk), .RSTN(rstn), .SCLK(sclk), .CSN(csn), .DIN(din),
        .SCAN_SOURCE(src), .CHANNEL_NUMBER_FIELD(fld), .PER_CHANNEL_SCAN_BITMAP(bmap),
        .CONV_NEXT(conv_next), .CONV_CHANNEL(chan), .CONV_INPUT_MODE(mode),
        .CONV_TWOS_COMPLEMENT(twos), .PAIR_PSEUDO_DIFF(pd), .PAIR_BIPOLAR(bp),
        .COMMON_REFERENCE_ENABLE(cr), .SEQUENCE_LENGTH_MINUS_ONE(len),
        .SEQUENCE_LOADED_COUNT(cnt), .SEQUENCE_ACTIVATED(act), .MODE_CMD_VALID(cmd_v),
        .MODE_CMD_WORD(cmd_word));

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    initial begin
        sys_clk = 1'b0;
        forever #2.5 sys_clk = ~sys_clk;
    end

    task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
        num_checks++;
        if (got !== exp) begin
            $display("wrong value %s expected %h seen %h", nm, exp, got);
            n_errors++;
        end
    endtask : chk

    // one-cycle advance pulse, then time for the ram read and decode to land
    task automatic step();
        @(negedge sys_clk) conv_next = 1'b1;
        @(negedge sys_clk) conv_next = 1'b0;
        repeat (4) @(negedge sys_clk);
    endtask : step

    // one-cycle pulses are counted away from the edge that launches them
    always @(negedge sys_clk) begin
        if (act === 1'b1) begin
            n_act <= n_act + 1;
        end
        if (cmd_v === 1'b1) begin
            n_cmd <= n_cmd + 1;
        end
    end

    task automatic wrap_up();
        $display("checks %0d errors %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : wrap_up

    // a hung link or handshake would otherwise run forever; all tests need ~11 us
    initial begin
        #100000;
        n_errors++;
        wrap_up();
    end

    // ------------------------------------------------------------
    // tests
    // ------------------------------------------------------------
    initial begin
        rstn = 1'b0;
        src = 2'h0;
        fld = 4'h0;
        bmap = 16'h0000;
        conv_next = 1'b0;
        repeat (5) @(negedge sys_clk);
        rstn = 1'b1;
        repeat (4) @(negedge sys_clk);
        chk("pairing reset", 16'h0000, {8'h00, pd});
        chk("polarity reset", 16'h0000, {8'h00, bp});
        chk("comref reset", 16'h0000, {15'h0000, cr});
        u_acfg_host.xfer(64'h8C04, 16);
        chk("pairing", 16'h0080, {8'h00, pd});
        chk("comref", 16'h0001, {15'h0000, cr});
        chk("comref mode", 16'h0003, {14'h0000, mode});
        u_acfg_host.xfer(64'h8A03, 16); // low unused bits set
        u_acfg_host.xfer(64'h9600, 16);
        u_acfg_host.xfer(64'hA0FF, 16); // select code of no register here
        u_acfg_host.xfer(64'h0097, 8); // short frame must be dropped
        u_acfg_host.xfer(64'h1234, 16);
        chk("pairing kept", 16'h0040, {8'h00, pd});
        chk("polarity", 16'h00C0, {8'h00, bp});
        chk("mode word", 16'h1234, cmd_word);
        chk("mode pulses", 16'h0001, 16'(n_cmd)); // short frame gave none
        foreach (dec[i]) begin
            @(negedge sys_clk) fld = dec[i][7:4];
            repeat (3) @(negedge sys_clk);
            chk("input mode", {14'h0000, dec[i][2:1]}, {14'h0000, mode});
            chk("twos", {15'h0000, dec[i][0]}, {15'h0000, twos});
            chk("field channel", {12'h000, dec[i][7:4]}, {12'h000, chan});
        end
        // bitmap walk with channels 3 and 9, wrapping
        @(negedge sys_clk) bmap = 16'h0208;
        src = 2'h1;
        repeat (4) @(negedge sys_clk);
        chk("bitmap first", 16'h0003, {12'h000, chan});
        step();
        chk("bitmap second", 16'h0009, {12'h000, chan});
        step();
        chk("bitmap wrap", 16'h0003, {12'h000, chan});
        // length four, two whole nibbles then one cut by chip select
        u_acfg_host.xfer(64'hB018, 16);
        u_acfg_host.xfer(64'h016B, 10);
        u_acfg_host.xfer(64'h0000, 16);
        chk("sequence_length_minus_one", 16'h0003, {8'h00, len});
        chk("activations", 16'h0001, 16'(n_act));
        chk("cut count", 16'h0003, {7'h00, cnt});
        @(negedge sys_clk) src = 2'h2;
        repeat (4) @(negedge sys_clk);
        foreach (seq_a[i]) begin
            chk("sequence channel", {12'h000, seq_a[i]}, {12'h000, chan});
            step();
        end
        // length one, three nibbles sent: extras dropped
        u_acfg_host.xfer(64'hB000, 16);
        u_acfg_host.xfer(64'h0739, 12);
        u_acfg_host.xfer(64'h0000, 16);
        chk("short length", 16'h0000, {8'h00, len});
        chk("activations", 16'h0002, 16'(n_act));
        chk("loaded count", 16'h0001, {7'h00, cnt});
        chk("single entry", 16'h0007, {12'h000, chan});
        step();
        chk("single wrap", 16'h0007, {12'h000, chan});
        chk("mode pulses", 16'h0003, 16'(n_cmd));
        wrap_up();
    end
endmodule : acfg_top_test
